// ==== hdl/acir_consts.vh ====
`ifndef ACIR_CONSTS_VH
`define ACIR_CONSTS_VH

// ==========================================================================
// Register indices on the serial management interface
`define ACIR_REG_CONV_CTRL    8'h0B
`define ACIR_REG_CONV_RESULT  8'h0C
`define ACIR_REG_IRQ_MASK     8'h0D
`define ACIR_REG_IRQ_REQUEST  8'h0E

// ==========================================================================
// Converter control fields
`define ACIR_CTRL_OVF_BIT     5
`define ACIR_CTRL_RDY_BIT     4
`define ACIR_CTRL_TRIG_BIT    3
`define ACIR_CTRL_EN_BIT      2
`define ACIR_CTRL_SEL_HI      1
`define ACIR_CTRL_SEL_LO      0

// ==========================================================================
// Interrupt mask and request layout (shared)
`define ACIR_IRQ_UV_BIT       7
`define ACIR_IRQ_UCMD_BIT     6
`define ACIR_IRQ_PERR_BIT     5
`define ACIR_IRQ_DONE_BIT     4
`define ACIR_IRQ_CMP_HI       3
`define ACIR_IRQ_CMP_LO       0

// ==========================================================================
// Reset values and full-scale code
`define ACIR_RST_CTRL         8'h00
`define ACIR_RST_RESULT       8'h00
`define ACIR_RST_MASK         8'h00
`define ACIR_RST_REQUEST      8'h00
`define ACIR_CODE_FULL        8'hFF

`endif

// ==== hdl/acir_conv_seq.v ====
`timescale 1ns/1ps
`include "acir_consts.vh"

// Conversion sequencer: trigger edge, status flags and result holding
module acir_conv_seq (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Control from register file
    input  wire       trig_wr,
    input  wire       trig_val,
    input  wire       conv_enable,
    // Converter core
    input  wire       core_done,
    input  wire [7:0] core_code,
    input  wire       core_over,
    // Status
    output reg        start_q,
    output reg        trig_q,
    output reg        ready_q,
    output reg        over_q,
    output reg  [7:0] result_q,
    output wire       done_evt
);

    wire start_d;

    // Only a 0-to-1 move of the trigger starts; a repeated 1 does nothing
    assign start_d  = trig_wr & trig_val & ~trig_q & conv_enable;
    assign done_evt = core_done;

    always @(posedge clk) begin
        if (rst) begin
            start_q  <= 1'b0;
            trig_q   <= 1'b0;
            ready_q  <= 1'b0;
            over_q   <= 1'b0;
            result_q <= `ACIR_RST_RESULT;
        end else begin
            start_q <= start_d;
            // Trigger holds its written value, never self-clears
            if (trig_wr) begin
                trig_q <= trig_val;
            end
            if (core_done) begin
                ready_q <= 1'b1;
                over_q  <= core_over;
                // Above full scale the code pins at the top
                result_q <= core_over ? `ACIR_CODE_FULL : core_code;
            end else if (start_d) begin
                ready_q <= 1'b0;
                over_q  <= 1'b0;
            end
        end
    end

endmodule

// ==== hdl/acir_ctrl.v ====
`timescale 1ns/1ps
`include "acir_consts.vh"

module acir_ctrl (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Register access from the serial management interface
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata_q,
    output reg        reg_rvalid_q,
    // Host interface error events
    input  wire       undefined_command_evt,
    input  wire       parity_error_evt,
    // Buck under-voltage levels, asynchronous
    input  wire [2:0] buck_undervoltage,
    // Comparator side
    input  wire [3:0] comparator_trip_evt,
    input  wire [3:0] comparator_enable,
    input  wire [3:0] pin_output_enables,
    // Converter core
    output reg        conv_start_q,
    output reg  [1:0] input_source_select_q,
    output reg        converter_enable_q,
    input  wire       conv_done,
    input  wire [7:0] conv_code,
    input  wire       conv_over,
    // Interrupt request pin
    output reg        irq_n_q
);

    // ======================================================================
    // Decode
    wire       sel_ctrl;
    wire       sel_result;
    wire       sel_mask;
    wire       sel_request;
    wire       wr_ctrl;

    assign sel_ctrl    = (reg_addr == `ACIR_REG_CONV_CTRL);
    assign sel_result  = (reg_addr == `ACIR_REG_CONV_RESULT);
    assign sel_mask    = (reg_addr == `ACIR_REG_IRQ_MASK);
    assign sel_request = (reg_addr == `ACIR_REG_IRQ_REQUEST);
    assign wr_ctrl     = reg_wr & sel_ctrl;

    // ======================================================================
    // Under-voltage synchroniser and edge
    reg  [2:0] uv_meta_q;
    reg  [2:0] uv_sync_q;
    reg  [2:0] uv_prev_q;
    wire       uv_evt;

    always @(posedge clk) begin
        if (rst) begin
            uv_meta_q <= 3'h0;
            uv_sync_q <= 3'h0;
            uv_prev_q <= 3'h0;
        end else begin
            uv_meta_q <= buck_undervoltage;
            uv_sync_q <= uv_meta_q;
            uv_prev_q <= uv_sync_q;
        end
    end

    // Edge so a lasting fault does not re-arm after a clear
    assign uv_evt = |(uv_sync_q & ~uv_prev_q);

    // ======================================================================
    // Control and interrupt mask registers
    reg  [7:0] mask_q;

    always @(posedge clk) begin
        if (rst) begin
            input_source_select_q <= 2'h0;
            converter_enable_q    <= 1'b0;
            mask_q                <= `ACIR_RST_MASK;
        end else begin
            if (wr_ctrl) begin
                input_source_select_q <=
                    reg_wdata[`ACIR_CTRL_SEL_HI:`ACIR_CTRL_SEL_LO];
                converter_enable_q <= reg_wdata[`ACIR_CTRL_EN_BIT];
            end
            if (reg_wr && sel_mask) begin
                mask_q <= reg_wdata;
            end
        end
    end

    // ======================================================================
    // Conversion sequencer
    wire       trig_q;
    wire       ready_q;
    wire       over_q;
    wire [7:0] result_q;
    wire       done_evt;
    wire       start_q;

    // Enable takes effect in the same write as the trigger
    acir_conv_seq u_seq (
        .clk         (clk),
        .rst         (rst),
        .trig_wr     (wr_ctrl),
        .trig_val    (reg_wdata[`ACIR_CTRL_TRIG_BIT]),
        .conv_enable (reg_wdata[`ACIR_CTRL_EN_BIT]),
        .core_done   (conv_done),
        .core_code   (conv_code),
        .core_over   (conv_over),
        .start_q     (start_q),
        .trig_q      (trig_q),
        .ready_q     (ready_q),
        .over_q      (over_q),
        .result_q    (result_q),
        .done_evt    (done_evt)
    );

    always @(posedge clk) begin
        if (rst) begin
            conv_start_q <= 1'b0;
        end else begin
            conv_start_q <= start_q;
        end
    end

    // ======================================================================
    // Interrupt sources
    reg  [7:0] set_evt;
    wire [3:0] cmp_ok;
    wire [7:0] request_q;
    wire       irq_n;

    // Pins driven as outputs cannot act as comparator inputs
    assign cmp_ok = comparator_enable & ~pin_output_enables;

    always @* begin
        set_evt = 8'h00;
        set_evt[`ACIR_IRQ_UV_BIT]   = uv_evt;
        set_evt[`ACIR_IRQ_UCMD_BIT] = undefined_command_evt;
        set_evt[`ACIR_IRQ_PERR_BIT] = parity_error_evt;
        set_evt[`ACIR_IRQ_DONE_BIT] = done_evt;
        set_evt[`ACIR_IRQ_CMP_HI:`ACIR_IRQ_CMP_LO] =
            comparator_trip_evt & cmp_ok;
    end

    acir_irq #(
        .WIDTH (8)
    ) u_irq (
        .clk       (clk),
        .rst       (rst),
        .set_evt   (set_evt),
        .clear_rd  (reg_rd & sel_request),
        .mask      (mask_q),
        .request_q (request_q),
        .irq_n_q   (irq_n)
    );

    always @(posedge clk) begin
        if (rst) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= irq_n;
        end
    end

    // ======================================================================
    // Read data
    reg [7:0] rd_mux;

    always @* begin
        rd_mux = 8'h00;
        if (sel_ctrl) begin
            rd_mux[`ACIR_CTRL_OVF_BIT]  = over_q;
            rd_mux[`ACIR_CTRL_RDY_BIT]  = ready_q;
            rd_mux[`ACIR_CTRL_TRIG_BIT] = trig_q;
            rd_mux[`ACIR_CTRL_EN_BIT]   = converter_enable_q;
            rd_mux[`ACIR_CTRL_SEL_HI:`ACIR_CTRL_SEL_LO] =
                input_source_select_q;
        end else if (sel_result) begin
            rd_mux = result_q;
        end else if (sel_mask) begin
            rd_mux = mask_q;
        end else if (sel_request) begin
            rd_mux = request_q;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            reg_rdata_q  <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd) begin
                reg_rdata_q <= rd_mux;
            end
        end
    end

endmodule

// ==== hdl/acir_irq.v ====
`timescale 1ns/1ps
`include "acir_consts.vh"

// Sticky request register with mask and clear-on-read
module acir_irq #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst,
    // Events and control
    input  wire [WIDTH-1:0] set_evt,
    input  wire             clear_rd,
    input  wire [WIDTH-1:0] mask,
    // Status
    output reg  [WIDTH-1:0] request_q,
    output reg              irq_n_q
);

    wire [WIDTH-1:0] request_d;

    // A set in the clearing cycle survives
    assign request_d = (clear_rd ? {WIDTH{1'b0}} : request_q) | set_evt;

    always @(posedge clk) begin
        if (rst) begin
            request_q <= `ACIR_RST_REQUEST;
            irq_n_q   <= 1'b1;
        end else begin
            request_q <= request_d;
            irq_n_q   <= ~|(request_d & mask);
        end
    end

endmodule

// ==== verification/acir_core_model.sv ====
`timescale 1ns/1ps
// ====================
// Converter core model
module acir_core_model #(
    parameter LAT = 6
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // From the block
    input  wire        start,
    input  wire [1:0]  sel,
    input  wire [35:0] levels,
    // Result
    output reg         done,
    output reg  [7:0]  code,
    output reg         over
);
    int cnt = 0;
    initial begin
        done = 1'b0;
        code = 8'h5A;
        over = 1'b0;
    end
    always @(posedge clk) begin
        done <= 1'b0;
        // Churn outside the done cycle
        code <= ~code;
        over <= ~over;
        if (rst) begin
            cnt <= 0;
        end else if (start) begin
            cnt <= LAT;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                done <= 1'b1;
                {over, code} <= levels[sel*9 +: 9];
            end
        end
    end
endmodule

// ==== verification/acir_ctrl_properties.sv ====
`timescale 1ns/1ps
// ============
// Port checker
module acir_ctrl_chk (
    // Clock and reset
    input logic       clk,
    input logic       rst,
    // Register access
    input logic       reg_wr,
    input logic [7:0] reg_wdata,
    input logic [7:0] reg_addr,
    input logic       reg_rd,
    input logic [7:0] reg_rdata_q,
    input logic       reg_rvalid_q,
    // Events and converter
    input logic       undefined_command_evt,
    input logic       parity_error_evt,
    input logic       conv_start_q,
    input logic       conv_done,
    input logic [7:0] conv_code,
    input logic       conv_over
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_rq(ev, logic [7:0] a);
        ev ##3 (reg_rd && reg_addr == a);
    endsequence
    AST_RVALID: assert property (reg_rd |=> reg_rvalid_q)
        else $error("read not answered");
    AST_START: assert property (
        conv_start_q |-> $past(reg_wr, 2) && $past(reg_wdata[3], 2) &&
            $past(reg_addr, 2) == 8'h0B)
        else $error("start without trigger");
    AST_ONE: assert property (conv_start_q |=> !conv_start_q)
        else $error("long start");
    AST_DONE: assert property (
        s_rq(conv_done, 8'h0E) |=> reg_rdata_q[4])
        else $error("no done request");
    AST_READY: assert property (
        s_rq(conv_done, 8'h0B) |=> reg_rdata_q[4])
        else $error("no ready");
    AST_OVF: assert property (
        s_rq(conv_done, 8'h0B) |=> reg_rdata_q[5] == $past(conv_over, 4))
        else $error("bad overflow");
    AST_RESULT: assert property (
        s_rq(conv_done, 8'h0C) |=> reg_rdata_q ==
            ($past(conv_over, 4) ? 8'hFF : $past(conv_code, 4)))
        else $error("bad result");
    AST_UCMD: assert property (
        s_rq(undefined_command_evt, 8'h0E) |=> reg_rdata_q[6])
        else $error("no command request");
    AST_PERR: assert property (
        s_rq(parity_error_evt, 8'h0E) |=> reg_rdata_q[5])
        else $error("no parity request");
endmodule
bind acir_ctrl acir_ctrl_chk i_acir_ctrl_chk (.clk, .rst, .reg_wr,
    .reg_wdata, .reg_addr, .reg_rd, .reg_rdata_q, .reg_rvalid_q,
    .undefined_command_evt, .parity_error_evt, .conv_start_q, .conv_done,
    .conv_code, .conv_over);

// ==== verification/acir_ctrl_tb_top.sv ====
`timescale 1ns/1ps
// ==========
// Bench top
module acir_ctrl_tb_top;
    logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata_q, conv_code, a;
    logic        undefined_command_evt = 0, parity_error_evt = 0;
    logic [2:0]  buck_undervoltage = 0;
    logic [3:0]  comparator_trip_evt = 0, comparator_enable = 0;
    logic [3:0]  pin_output_enables = 0;
    logic [1:0]  input_source_select_q;
    logic        reg_rvalid_q, conv_start_q, converter_enable_q;
    logic        conv_done, conv_over, irq_n_q;
    logic [35:0] levels;
    logic [8:0]  lv;
    logic [7:0]  exp_q[$];
    logic [7:0]  idx[3] = '{8'h0B, 8'h0C, 8'h0E};
    int          fails = 0, checked = 0, starts = 0, n;

    acir_ctrl i_acir_ctrl (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata_q, .reg_rvalid_q, .undefined_command_evt,
        .parity_error_evt, .buck_undervoltage, .comparator_trip_evt,
        .comparator_enable, .pin_output_enables, .conv_start_q,
        .input_source_select_q, .converter_enable_q, .conv_done,
        .conv_code, .conv_over, .irq_n_q);
    acir_core_model i_acir_core_model (.clk, .rst, .start(conv_start_q),
        .sel(input_source_select_q), .levels, .done(conv_done),
        .code(conv_code), .over(conv_over));

    always #12.5 clk = ~clk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk);
        reg_addr = ad;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge clk);
        reg_wr = 0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        @(negedge clk);
        reg_addr = ad;
        reg_rd = 1;
        exp_q.push_back(e);
        @(negedge clk);
        reg_rd = 0;
    endtask
    task automatic idle(input int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic close_out;
        if (fails == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    function automatic logic [7:0] expv(input logic [7:0] ad, input int s);
        if (ad == 8'h0B)
            return {2'b00, lv[8], 3'b111, 2'(s)};
        if (ad == 8'h0C)
            return lv[8] ? 8'hFF : lv[7:0];
        return 8'h10;
    endfunction

    // Oldest note against each answer
    always @(negedge clk) begin
        if (conv_start_q === 1'b1)
            starts++;
        if (reg_rvalid_q === 1'b1) begin
            if (exp_q.size() == 0)
                chk(reg_rdata_q, ~reg_rdata_q);
            else
                chk(reg_rdata_q, exp_q.pop_front());
        end
    end

    initial begin
        #100000;
        fails++;
        close_out;
    end

    initial begin
        void'($urandom(52));
        for (int k = 0; k < 4; k++) begin
            lv = 9'($urandom);
            levels[k*9 +: 9] = {k % 2 == 1, lv[7:0]};
        end
        idle(6);
        rst = 0;
        rd(8'h0B, 8'h00);
        rd(8'h20, 8'h00);
        wr(8'h0C, 8'h5A);
        rd(8'h0C, 8'h00);
        wr(8'h0D, 8'h10);
        rd(8'h0D, 8'h10);
        for (int s = 0; s < 4; s++) begin
            lv = levels[s*9 +: 9];
            wr(8'h0B, 8'h04 | 8'(s));
            wr(8'h0B, 8'h0C | 8'(s));
            rd(8'h0B, 8'h0C | 8'(s));
            n = 0;
            while (conv_done !== 1'b1 && n < 50) begin
                @(negedge clk);
                n++;
            end
            idle(2);
            chk({7'h00, irq_n_q}, 8'h00);
            chk({5'h00, converter_enable_q, input_source_select_q},
                8'h04 | 8'(s));
            for (int j = 0; j < 3; j++) begin
                a = idx[(s + j) % 3];
                rd(a, expv(a, s));
            end
            idle(2);
            chk({7'h00, irq_n_q}, 8'h01);
            wr(8'h0B, 8'h0C | 8'(s));
            idle(20);
            chk(8'(starts), 8'(s + 1));
        end
        wr(8'h0D, 8'h00);
        comparator_enable = 4'h2;
        @(negedge clk);
        undefined_command_evt = 1;
        parity_error_evt = 1;
        comparator_trip_evt = 4'h6;
        buck_undervoltage = 3'h4;
        @(negedge clk);
        undefined_command_evt = 0;
        parity_error_evt = 0;
        comparator_trip_evt = 4'h0;
        idle(1);
        chk({7'h00, irq_n_q}, 8'h01);
        rd(8'h0E, 8'hE2);
        rd(8'h0E, 8'h00);
        idle(4);
        close_out;
    end
endmodule
